// ==== rtl/mna_pkg.sv ====
package mna_pkg;

	// datagram fields handed over by the frame engine (framing and crc live there)
	typedef struct packed {
		logic        valid;    // one-cycle pulse: a complete datagram was received
		logic        crc_ok;   // checksum of that datagram was correct
		logic [7:0]  node;     // node address field
		logic [7:0]  reg_addr; // register address, top bit set on writes
		logic [31:0] data;     // write data
	} mna_frame_t;

	// one drive channel for a two-way pin
	typedef struct packed {
		logic value;
		logic oe;
	} mna_pin_t;

	// register map of this block's own registers
	localparam logic [7:0] MNA_WRITE_FLAG   = 8'h80;  // added to the address of a write
	localparam int         MNA_REG_BITS     = 7;      // plain register address width
	localparam logic [6:0] MNA_REG_NODE     = 7'h03;  // node address and reply delay
	localparam logic [6:0] MNA_REG_GPIO     = 7'h04;  // chain output pin control

	// field positions
	localparam int MNA_NODE_LSB   = 0;
	localparam int MNA_NODE_W     = 8;
	localparam int MNA_DELAY_LSB  = 8;
	localparam int MNA_DELAY_W    = 4;
	localparam int MNA_GPIO_VAL   = 0;
	localparam int MNA_GPIO_DIR   = 1;

	// reset values: everything clears at power-up
	localparam logic [7:0] MNA_NODE_RESET  = 8'h00;
	localparam logic [3:0] MNA_DELAY_RESET = 4'h0;
	localparam logic [1:0] MNA_GPIO_RESET  = 2'h0;

	// reserved and special address values
	localparam logic [7:0] MNA_NODE_UNSET  = 8'h00;  // unaddressed node
	localparam logic [7:0] MNA_NODE_MASTER = 8'hFF;  // replies toward the master
	localparam int         MNA_MAX_NODES   = 255;

	// timing in bit times
	localparam int         MNA_DELAY_STEP  = 8;      // reply delay granularity
	localparam int         MNA_TAIL_BITS   = 4;      // driver hold after the last bit
	localparam int         MNA_CNT_W       = 8;
	localparam logic [7:0] MNA_DELAY_STEP_C = MNA_CNT_W'(MNA_DELAY_STEP);
	localparam logic [7:0] MNA_TAIL_C       = MNA_CNT_W'(MNA_TAIL_BITS);

	// pin synchroniser lanes
	localparam int MNA_SYN_W     = 4;
	localparam int MNA_SYN_POS   = 0;
	localparam int MNA_SYN_CHAIN = 1;
	localparam int MNA_SYN_RING  = 2;
	localparam int MNA_SYN_IFSEL = 3;

	typedef enum logic [1:0] {
		MNA_IDLE,
		MNA_WAIT,
		MNA_SEND,
		MNA_TAIL
	} mna_state_t;

endpackage

// ==== rtl/mna_sync.sv ====
`timescale 1ns/1ns
// two-stage synchroniser, one lane per asynchronous input
module mna_sync
	import mna_pkg::*;
#(
	parameter int WIDTH = 4
) (
	input  wire logic             i_clock,
	input  wire logic             i_rst_n,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : lane
			logic stage1_reg;
			logic stage2_reg;
			// first stage feeds only the second stage
			always_ff @(posedge i_clock or negedge i_rst_n) begin
				if (!i_rst_n) begin
					stage1_reg <= 1'b0;
					stage2_reg <= 1'b0;
				end else begin
					stage1_reg <= i_async[g];
					stage2_reg <= stage1_reg;
				end
			end
			assign o_sync[g] = stage2_reg;
		end
	endgenerate

endmodule

// ==== rtl/mna_node.sv ====
`timescale 1ns/1ns
// Overview of operation
// - chain input level picks the hardware address of an unprogrammed node.
// - chained addressing lets up to 255 nodes share one bus.
// - unprogrammed node answers address 0 with chain input low, 1 when high.
// - chain output controls the bus switch; low connects the next segment.
// - ring operation only with ring select high and interface in uart mode.
// - in ring operation positive wire is input only, negative wire output only.
// - in ring operation an unprogrammed node holds its output wire high.
// - in ring operation a nonzero address makes the node relay input to output.
// - in a full ring requests reach all nodes and replies pass downstream.
// - ring operation ignores the chain input unless two rings share a start.
// - all registers clear to zero at power-up.
// - writes carry register address plus 0x80, reads the plain address.
// - ring select low gives standard bus operation.
// - only datagrams with good checksum and own node address are acted on.
// - the all-ones address is reserved for replies and never assigned.
// - read replies wait a delay set in steps of eight bit times.
module mna_node
	import mna_pkg::*;
(
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	input  wire logic        i_wire_pos_in,
	input  wire logic        i_chain_in_pin,
	input  wire logic        i_ring_select_pin,
	input  wire logic        i_interface_select,
	input  wire logic        i_ring_shared_start,
	input  wire mna_frame_t  i_frame,
	input  wire logic        i_bit_tick,
	input  wire logic        i_tx_bit,
	input  wire logic        i_tx_done,
	output logic             o_rx_bit,
	output mna_pin_t         o_wire_pos,
	output mna_pin_t         o_wire_neg,
	output mna_pin_t         o_chain_out_pin,
	output logic             o_ring_mode,
	output logic             o_addressed,
	output logic [7:0]       o_node_address,
	output logic             o_read_req,
	output logic [6:0]       o_read_addr,
	output logic [31:0]      o_read_data,
	output logic             o_reply_go,
	output logic             o_reply_active
);

	typedef struct packed {
		mna_state_t  state;
		logic [7:0]  node_addr;
		logic [3:0]  delay_set;
		logic [1:0]  gpio;
		logic [7:0]  cnt;
		logic        read_req;
		logic [6:0]  read_addr;
		logic [31:0] read_data;
		logic        reply_go;
		mna_pin_t    pos;
		mna_pin_t    neg;
	} mna_node_state_t;

	mna_node_state_t st_reg;
	mna_node_state_t st_next;

	logic [MNA_SYN_W-1:0] syn;
	logic                 ring;
	logic                 unset;
	logic                 chain_level;
	logic [7:0]           eff_addr;
	logic                 hit;
	logic                 is_write;
	logic [6:0]           plain_addr;
	logic [7:0]           delay_bits;

	// pins from outside the clock domain
	mna_sync #(
		.WIDTH (MNA_SYN_W)
	) u_sync (
		.i_clock (i_clock),
		.i_rst_n (i_rst_n),
		.i_async ({i_interface_select, i_ring_select_pin, i_chain_in_pin, i_wire_pos_in}),
		.o_sync  (syn)
	);

	// mode and address decode
	assign ring  = syn[MNA_SYN_RING] & syn[MNA_SYN_IFSEL];
	assign unset = (st_reg.node_addr == MNA_NODE_UNSET);
	// chain level only counts outside ring, or when two rings share a start
	assign chain_level = syn[MNA_SYN_CHAIN] & (~ring | i_ring_shared_start);
	// unprogrammed node answers 0 or 1 by chain level
	assign eff_addr = unset ? {7'h00, chain_level} : st_reg.node_addr;
	// only good frames for this node are acted on
	assign hit = i_frame.valid & i_frame.crc_ok & (i_frame.node == eff_addr)
	           & (i_frame.node != MNA_NODE_MASTER);
	assign is_write   = (i_frame.reg_addr & MNA_WRITE_FLAG) != 8'h00;
	assign plain_addr = i_frame.reg_addr[MNA_REG_BITS-1:0];
	// delay of zero setting still waits one step
	assign delay_bits = (st_reg.delay_set == 4'h0) ? MNA_DELAY_STEP_C
	                  : 8'(st_reg.delay_set * MNA_DELAY_STEP_C);

	// next-state logic
	always_comb begin
		st_next          = st_reg;
		st_next.read_req = 1'b0;
		st_next.reply_go = 1'b0;

		// register writes and read requests
		if (hit && is_write) begin
			if (plain_addr == MNA_REG_NODE) begin
				// all-ones address can never be taken
				if (i_frame.data[MNA_NODE_LSB +: MNA_NODE_W] != MNA_NODE_MASTER) begin
					st_next.node_addr = i_frame.data[MNA_NODE_LSB +: MNA_NODE_W];
				end
				st_next.delay_set = i_frame.data[MNA_DELAY_LSB +: MNA_DELAY_W];
			end else if (plain_addr == MNA_REG_GPIO) begin
				st_next.gpio = i_frame.data[MNA_GPIO_DIR:MNA_GPIO_VAL];
			end
		end

		// reply sequencing, counted in bit times
		unique case (st_reg.state)
			MNA_IDLE: begin
				if (hit && !is_write) begin
					st_next.read_req  = 1'b1;
					st_next.read_addr = plain_addr;
					unique case (plain_addr)
						MNA_REG_NODE: st_next.read_data = {20'h00000, st_reg.delay_set, st_reg.node_addr};
						MNA_REG_GPIO: st_next.read_data = {30'h0, st_reg.gpio};
						default:      st_next.read_data = 32'h00000000;
					endcase
					st_next.cnt   = 8'h00;
					st_next.state = MNA_WAIT;
				end
			end
			MNA_WAIT: begin
				if (i_bit_tick) begin
					if (st_reg.cnt + 8'h01 >= delay_bits) begin
						st_next.reply_go = 1'b1;
						st_next.state    = MNA_SEND;
					end else begin
						st_next.cnt = st_reg.cnt + 8'h01;
					end
				end
			end
			MNA_SEND: begin
				if (i_tx_done) begin
					st_next.cnt   = 8'h00;
					st_next.state = MNA_TAIL;
				end
			end
			MNA_TAIL: begin
				// driver stays on for a few idle bits after the last bit
				if (i_bit_tick) begin
					if (st_reg.cnt + 8'h01 >= MNA_TAIL_C) begin
						st_next.state = MNA_IDLE;
					end else begin
						st_next.cnt = st_reg.cnt + 8'h01;
					end
				end
			end
		endcase

		// wire drivers
		if (ring) begin
			// positive wire is receive only, negative wire always driven
			st_next.pos.oe    = 1'b0;
			st_next.pos.value = 1'b1;
			st_next.neg.oe    = 1'b1;
			if (st_next.node_addr == MNA_NODE_UNSET) begin
				st_next.neg.value = 1'b1;
			end else if (st_next.state == MNA_SEND) begin
				st_next.neg.value = i_tx_bit;  // own reply enters the ring
			end else if (st_next.state == MNA_TAIL) begin
				st_next.neg.value = 1'b1;
			end else begin
				st_next.neg.value = syn[MNA_SYN_POS];
			end
		end else begin
			// standard bus: drive both wires differentially only while replying
			// drivers follow the reply state computed above, no feedback through a net
			st_next.pos.oe    = (st_next.state == MNA_SEND) | (st_next.state == MNA_TAIL);
			st_next.neg.oe    = st_next.pos.oe;
			st_next.pos.value = (st_next.state == MNA_SEND) ? i_tx_bit : 1'b1;
			st_next.neg.value = (st_next.state == MNA_SEND) ? ~i_tx_bit : 1'b0;
		end
	end

	// state register, loaded with reset values at power-up
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_reg.state     <= MNA_IDLE;
			st_reg.node_addr <= MNA_NODE_RESET;
			st_reg.delay_set <= MNA_DELAY_RESET;
			st_reg.gpio      <= MNA_GPIO_RESET;
			st_reg.cnt       <= 8'h00;
			st_reg.read_req  <= 1'b0;
			st_reg.read_addr <= 7'h00;
			st_reg.read_data <= 32'h00000000;
			st_reg.reply_go  <= 1'b0;
			st_reg.pos       <= 2'h2;             // idle high, released
			st_reg.neg       <= 2'h0;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs
	assign o_rx_bit        = syn[MNA_SYN_POS];
	assign o_wire_pos      = st_reg.pos;
	assign o_wire_neg      = st_reg.neg;
	// chain pin released until configured as output; low connects next segment
	assign o_chain_out_pin = '{value: st_reg.gpio[MNA_GPIO_VAL],
	                           oe:    st_reg.gpio[MNA_GPIO_DIR]};
	assign o_ring_mode     = ring;
	assign o_addressed     = ~unset;
	assign o_node_address  = st_reg.node_addr;
	assign o_read_req      = st_reg.read_req;
	assign o_read_addr     = st_reg.read_addr;
	assign o_read_data     = st_reg.read_data;
	assign o_reply_go      = st_reg.reply_go;
	assign o_reply_active  = (st_reg.state == MNA_SEND) | (st_reg.state == MNA_TAIL);

endmodule

// ==== sim/mna_node_assertions.sv ====
`timescale 1ns/1ns
// watches the node's outputs against its frame input
module mna_node_checker
	import mna_pkg::*;
(
	input wire logic       i_clock,
	input wire logic       i_rst_n,
	input wire mna_frame_t i_frame,
	input wire logic       o_rx_bit,
	input wire mna_pin_t   o_wire_pos,
	input wire mna_pin_t   o_wire_neg,
	input wire logic       o_ring_mode,
	input wire logic       o_addressed,
	input wire logic [7:0] o_node_address,
	input wire logic       o_read_req,
	input wire logic       o_reply_go,
	input wire logic       o_reply_active
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	// ring wiring and forwarding
	a_ring_wire_dir: assert property (o_ring_mode && $past(o_ring_mode) |-> !o_wire_pos.oe && o_wire_neg.oe)
		else $error("ring wire direction wrong");
	a_ring_idle_high: assert property (o_ring_mode && $past(o_ring_mode) && !o_addressed |-> o_wire_neg.value)
		else $error("unaddressed ring node not idle high");
	a_ring_relay: assert property (o_ring_mode && $past(o_ring_mode, 3) && o_addressed && !o_reply_active
		|-> o_wire_neg.value == $past(o_rx_bit))
		else $error("ring data not relayed");
	// standard bus drivers
	a_std_release: assert property (!o_ring_mode && !$past(o_ring_mode) && !o_reply_active
		|-> !o_wire_pos.oe && !o_wire_neg.oe)
		else $error("drivers on while idle");
	a_std_drive: assert property (!o_ring_mode && !$past(o_ring_mode) && o_reply_active
		|-> o_wire_pos.oe && o_wire_neg.oe && o_wire_pos.value != o_wire_neg.value)
		else $error("reply not driven differentially");
	// reply timing
	a_reply_wait: assert property (o_read_req |=> !o_reply_go [*8])
		else $error("reply started too early");
	a_reply_active: assert property (o_reply_go |-> o_reply_active)
		else $error("reply start without active state");
	// refused frames and address values
	a_bad_crc: assert property (i_frame.valid && !i_frame.crc_ok && !$past(i_frame.valid)
		|=> !o_read_req && $stable(o_node_address))
		else $error("bad checksum frame acted on");
	a_master_addr: assert property (i_frame.valid && i_frame.node == MNA_NODE_MASTER && !$past(i_frame.valid)
		|=> !o_read_req)
		else $error("master address matched");
	a_never_master: assert property (o_node_address != MNA_NODE_MASTER)
		else $error("node holds master address");
	a_addr_match: assert property (i_frame.valid && o_addressed && i_frame.node != o_node_address
		&& !$past(i_frame.valid) |=> !o_read_req)
		else $error("frame for another address matched");
	c_reply: cover property (o_reply_go);
	c_ring_relay: cover property (o_ring_mode && o_addressed);
	c_read: cover property (o_read_req);
endmodule
bind mna_node mna_node_checker u_chk (.i_clock, .i_rst_n, .i_frame, .o_rx_bit, .o_wire_pos, .o_wire_neg,
	.o_ring_mode, .o_addressed, .o_node_address, .o_read_req, .o_reply_go, .o_reply_active);

// ==== sim/mna_host.sv ====
`timescale 1ns/1ns
// frame side: bit ticks every four clocks, a twelve bit reply once the node starts
module mna_host (
	input  wire logic i_clock,
	input  wire logic i_rst_n,
	input  wire logic i_reply_go,
	output logic      o_bit_tick = 0,
	output logic      o_tx_bit   = 1,
	output logic      o_tx_done  = 0
);
	int div  = 0;
	int left = 0;
	int seed = 32'haae101a9;
	logic last;
	// drives just after each rising edge, each output assigned at most once per step
	always @(posedge i_clock) begin
		#1;
		div = (div + 1) % 4;
		o_bit_tick = (div == 0);
		last = 1'b0;
		if (!i_rst_n)
			left = 0;
		else if (i_reply_go === 1'b1)
			left = 12;
		if (o_bit_tick && left > 0) begin
			o_tx_bit = 1'($random(seed));
			left--;
			last = (left == 0); // last reply bit
		end
		o_tx_done = last;
	end
endmodule

// ==== sim/uart_multi_node_addressing_bench.sv ====
`timescale 1ns/1ns
module uart_multi_node_addressing_bench;
	import mna_pkg::*;
	logic        clk = 0, rst_n = 0, pos = 1, chain = 0, ring = 0, ifsel = 1, shared = 0;
	mna_frame_t  fr = '0;
	logic        tick, txb, done, rxb, ringm, addrd, rreq, go, act;
	mna_pin_t    wp, wn, cp;
	logic [7:0]  na;
	logic [6:0]  ra;
	logic [31:0] rdat;
	int          errors = 0, comparisons = 0, cyc = 0, seed = 32'haae101a9, n, nreq = 0;
	int          tcnt = 0, t0 = 0, gap = 0, node_m = 0, dly_m = 0, gpio_m = 0;
	logic        q[$];
	always #4 clk = ~clk;
	mna_node uut (.i_clock(clk), .i_rst_n(rst_n), .i_wire_pos_in(pos), .i_chain_in_pin(chain),
		.i_ring_select_pin(ring), .i_interface_select(ifsel), .i_ring_shared_start(shared),
		.i_frame(fr), .i_bit_tick(tick), .i_tx_bit(txb), .i_tx_done(done), .o_rx_bit(rxb),
		.o_wire_pos(wp), .o_wire_neg(wn), .o_chain_out_pin(cp), .o_ring_mode(ringm),
		.o_addressed(addrd), .o_node_address(na), .o_read_req(rreq), .o_read_addr(ra),
		.o_read_data(rdat), .o_reply_go(go), .o_reply_active(act));
	mna_host host (.i_clock(clk), .i_rst_n(rst_n), .i_reply_go(go), .o_bit_tick(tick),
		.o_tx_bit(txb), .o_tx_done(done));
	task automatic print_verdict;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// counts reads and reply delay in bit ticks, cuts a hang short
	always @(posedge clk) begin
		cyc++;
		if (rreq === 1'b1) begin
			nreq++;
			t0 = tcnt;
		end
		if (go === 1'b1)
			gap = tcnt - t0;
		tcnt += (tick === 1'b1);
		if (cyc == 20000) begin
			errors++;
			print_verdict();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// address the node answers to, by the model
	function automatic logic [7:0] eff();
		return node_m ? 8'(node_m) : 8'(chain & (!(ring & ifsel) | shared));
	endfunction
	task automatic send(input logic [7:0] nd, input logic [7:0] a, input logic [31:0] d, input logic ok);
		@(posedge clk) #1;
		fr = '{1'b1, ok, nd, a, d};
		@(posedge clk) #1;
		fr.valid = 0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] nd, input logic [6:0] a, input logic [31:0] d, input logic ok);
		if (ok && nd == eff()) begin
			if (a == MNA_REG_NODE && d[7:0] != 8'hFF)
				node_m = d[7:0];
			if (a == MNA_REG_NODE)
				dly_m = d[11:8];
			if (a == MNA_REG_GPIO)
				gpio_m = d[1:0];
		end
		send(nd, {1'b1, a}, d, ok);
		chk(na, node_m);
		chk(addrd, node_m != 0);
		chk(cp, {gpio_m[0], gpio_m[1]});
	endtask
	task automatic rd(input logic [7:0] nd, input logic [6:0] a);
		int k;
		k = nreq;
		gap = -1;
		send(nd, {1'b0, a}, $random(seed), 1'b1);
		chk(nreq - k, nd == eff());
		if (nd == eff()) begin
			chk(ra, a);
			chk(rdat, a == MNA_REG_NODE ? dly_m * 256 + node_m : a == MNA_REG_GPIO ? gpio_m : 0);
			for (k = 0; k < 900 && (act !== 1'b0 || gap < 0); k++)
				@(posedge clk);
			#1;
			chk(gap, 8 * (dly_m ? dly_m : 1));
		end
	endtask
	initial begin
		repeat (2) @(posedge clk);
		#1 rst_n = 1;
		repeat (3) @(posedge clk);
		// hardware address from the chain level, refused writes
		rd(8'h00, MNA_REG_NODE);
		rd(8'h01, MNA_REG_NODE);
		chain = 1;
		repeat (3) @(posedge clk);
		rd(8'h01, MNA_REG_GPIO);
		rd(8'hFF, MNA_REG_GPIO);
		wr(8'h01, MNA_REG_NODE, 32'h000000FF, 1'b1);
		wr(8'h01, MNA_REG_NODE, 32'h00000005, 1'b0);
		n = 1 + {$random(seed)} % 254;
		wr(8'h01, MNA_REG_NODE, 32'(n + 256 * (1 + {$random(seed)} % 3)), 1'b1);
		wr(8'(node_m), MNA_REG_GPIO, 32'h00000002, 1'b1);
		rd(8'(node_m), MNA_REG_NODE);
		rd(8'(node_m), MNA_REG_GPIO);
		rd(8'(node_m), 7'h7F);
		rd(8'h00, MNA_REG_NODE);
		$display("standard bus test done");
		// ring operation after a second reset
		ring = 1;
		rst_n = 0;
		node_m = 0;
		dly_m = 0;
		gpio_m = 0;
		repeat (2) @(posedge clk);
		#1 rst_n = 1;
		repeat (3) @(posedge clk);
		#1 chk(ringm, 1'b1);
		repeat (20) begin
			pos = 1'($random(seed));
			@(posedge clk) #1;
			chk(wn, 2'b11);
		end
		rd(8'h00, MNA_REG_NODE);
		shared = 1;
		rd(8'h01, MNA_REG_GPIO);
		wr(8'h01, MNA_REG_NODE, 32'(1 + {$random(seed)} % 254), 1'b1);
		repeat (30) begin
			pos = 1'($random(seed));
			q.push_back(pos);
			@(posedge clk) #1;
			if (q.size() == 3)
				chk(wn.value, q.pop_front());
		end
		$display("ring test done");
		// ring select without uart interface stays standard
		ifsel = 0;
		repeat (3) @(posedge clk);
		#1 chk(ringm, 1'b0);
		$display("mode test done");
		print_verdict();
	end
endmodule
